// File: verilog/hpb_pkg.sv
// hpb_pkg: constants, modes and state layout of the host parallel port.
// assumes one 20 MHz clock; every host pin is already synchronous to it.
package hpb_pkg;

  localparam int DEPTH = 16;           // buffer entries
  localparam int DW    = 16;           // bits per entry
  localparam int PW    = 4;            // pointer width
  localparam int CW    = 5;            // fill count width

  // byte addresses of the register map
  localparam logic [6:0] A_BUSW0 = 7'h00;
  localparam logic [6:0] A_BUSW1 = 7'h01;
  localparam logic [6:0] A_STAT  = 7'h04;
  localparam logic [6:0] A_ERR   = 7'h08;
  localparam logic [6:0] A_CLBA  = 7'h0c;
  localparam logic [6:0] A_HLBA  = 7'h10;
  localparam logic [6:0] A_SCC   = 7'h14;
  localparam logic [6:0] A_REV   = 7'h16;
  localparam logic [6:0] A_CTRL  = 7'h18;
  localparam logic [6:0] A_FAT   = 7'h1c;
  localparam logic [6:0] A_BUF   = 7'h40;   // 0x40..0x7f, bit 6 selects

  // control register fields
  localparam int CTRL_EN_BRDY = 8;
  localparam int CTRL_EN_ERR  = 9;
  localparam int CTRL_EN_CFG  = 10;
  localparam int CTRL_CLR_IRQ = 11;

  // status register fields driven by this block
  localparam int STAT_BRDY = 6;
  localparam int STAT_DIR  = 7;

  // command field in sector_count_command[15:8], count in [7:0]
  localparam logic [7:0] CMD_IDENTIFY = 8'h01;
  localparam logic [7:0] CMD_READ     = 8'h03;
  localparam logic [7:0] CMD_WRITE    = 8'h04;
  localparam logic [16:0] SECTOR_WORDS = 17'h00100;
  localparam logic [16:0] MAX_SECTORS  = 17'h00100;

  // revision value is arbitrary
  localparam logic [15:0] REVISION = 16'h0a01;

  typedef enum logic [1:0] {
    HPB_IDLE  = 2'b00,
    HPB_READ  = 2'b01,
    HPB_WRITE = 2'b10
  } hpb_mode_t;

  typedef struct packed {
    logic [DEPTH-1:0][DW-1:0] mem;
    logic [PW-1:0]            wptr;
    logic [PW-1:0]            rptr;
    logic [CW-1:0]            count;
    hpb_mode_t                mode;
    logic                     dir;
    logic [16:0]              host_left;
    logic [16:0]              fill_left;
    logic [6:0]               addr;
    logic [6:0]               waddr;
    logic [15:0]              wdata;
    logic                     wr_armed;
    logic                     rd_armed;
    logic                     rd_odd;
    logic [7:0]               stage;
    logic                     bus_width;
    logic [27:0]              host_lba;
    logic [15:0]              sec_cmd;
    logic [31:0]              ctrl;
    logic                     err_q;
    logic                     pending;
    logic                     irq;
    logic                     ready;
    logic [15:0]              dout;
    logic                     doe_n;
    logic                     fill_ready;
    logic                     drain_valid;
    logic [15:0]              drain_data;
    logic                     cmd_start;
  } hpb_state_t;

endpackage : hpb_pkg

// File: verilog/hpb_host_port.sv
// hpb_host_port: host register port, sector buffer and interrupt request.
// assumes host pins sampled on sys_clk; card engine speaks valid/ready.
`timescale 1ns/100ps

// Function
// - sixteen by sixteen-bit sector buffer
// - ready high when buffer usable in direction
// - direction flag 0 read, 1 write
// - identify/read hold read direction until done
// - write command holds write direction until done
// - ready low two cycles after last read
// - ready low two cycles after last write
// - buffer writes while ready low are discarded
// - irq held until clear bit written or all enables cleared
// - irq low two cycles after clear write
// - byte mode decodes seven bits, little endian
// - word mode decodes address bits 6:1
// - buffer window at 0x40-0x7f / word 0x20-0x3f
// - bus width bit written at 0x00 or 0x01, read back at 0x00 only
// - 28-bit host block address read-write
// - read-only 32-bit error register
// - irq low while all enables clear
// - bus width selects data and address lanes
module hpb_host_port (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        clk_en,
  input  wire logic [6:0]  host_address,
  input  wire logic [15:0] host_data_in,
  output logic      [15:0] host_data_out,
  output logic             host_data_oe_n,
  input  wire logic        host_chip_enable_n,
  input  wire logic        host_write_enable_n,
  input  wire logic        host_output_enable_n,
  output logic             buffer_ready_out,
  output logic             host_irq_out,
  input  wire logic [31:0] status_in,
  input  wire logic [31:0] error_in,
  input  wire logic [27:0] config_lba_in,
  input  wire logic [15:0] fat_status_in,
  input  wire logic        config_done_event,
  input  wire logic        card_fill_valid,
  input  wire logic [15:0] card_fill_data,
  output logic             card_fill_ready,
  output logic             card_drain_valid,
  output logic      [15:0] card_drain_data,
  input  wire logic        card_drain_ready,
  output logic             cmd_start,
  output logic      [15:0] sector_count_command,
  output logic      [27:0] host_block_address
);

  hpb_pkg::hpb_state_t s;
  hpb_pkg::hpb_state_t next_s;

  // one byte of the register map; buffer bytes come from the head entry
  function automatic logic [7:0] rd_byte(input hpb_pkg::hpb_state_t st,
                                         input logic [6:0] a,
                                         input logic [31:0] stat,
                                         input logic [31:0] err,
                                         input logic [27:0] clba,
                                         input logic [15:0] fat);
    logic [31:0] w;
    logic [7:0]  r;
    w = 32'h0000_0000;
    r = 8'h00;
    if (a[6]) begin
      r = a[0] ? st.mem[st.rptr][15:8] : st.mem[st.rptr][7:0];
    end else begin
      case ({a[6:2], 2'b00})
        hpb_pkg::A_BUSW0: w = {31'h0, st.bus_width} << {a[1:0], 3'b000};
        hpb_pkg::A_STAT:  w = stat;
        hpb_pkg::A_ERR:   w = err;
        hpb_pkg::A_CLBA:  w = {4'h0, clba};
        hpb_pkg::A_HLBA:  w = {4'h0, st.host_lba};
        hpb_pkg::A_SCC:   w = {hpb_pkg::REVISION, st.sec_cmd};
        hpb_pkg::A_CTRL:  w = st.ctrl;
        hpb_pkg::A_FAT:   w = {16'h0000, fat};
        default: w = 32'h0000_0000;
      endcase
      if ({a[6:2], 2'b00} == hpb_pkg::A_BUSW0 && a[1]) begin
        w = 32'h0000_0000;
      end
      if ({a[6:2], 2'b00} == hpb_pkg::A_BUSW0 && !a[1]) begin
        w = {31'h0, st.bus_width};
      end
      r = (a[1:0] == 2'b00) ? w[7:0] :
          (a[1:0] == 2'b01) ? w[15:8] :
          (a[1:0] == 2'b10) ? w[23:16] : w[31:24];
    end
    return r;
  endfunction : rd_byte

  logic [6:0]  wb_base;
  logic [6:0]  rb_base;
  logic [6:0]  ba;
  logic [7:0]  bd;
  logic        commit;
  logic        pop;
  logic        push;
  logic        fill;
  logic        drain;
  logic [15:0] push_word;
  logic [16:0] words;
  logic        brdy_rise;
  logic        err_rise;
  logic        events;
  logic        any_en;

  // next-state logic for every register of the port
  always_comb begin
    next_s    = s;
    next_s.cmd_start = 1'b0;
    commit    = s.wr_armed & host_write_enable_n;
    pop       = 1'b0;
    push      = 1'b0;
    push_word = s.wdata;
    words     = 17'h00000;
    ba        = 7'h00;
    bd        = 8'h00;
    // word mode forces address bit 0 low
    wb_base   = s.bus_width ? {s.waddr[6:1], 1'b0} : s.waddr;
    rb_base   = s.bus_width ? {s.addr[6:1], 1'b0} : s.addr;

    // internal address register and write capture
    if (!host_chip_enable_n) begin
      next_s.addr = host_address;
    end
    if (!host_chip_enable_n && !host_write_enable_n) begin
      next_s.waddr    = host_address;
      next_s.wdata    = host_data_in;
      next_s.wr_armed = 1'b1;
    end else if (host_write_enable_n) begin
      next_s.wr_armed = 1'b0;
    end

    // a word read or odd-byte read of the buffer pops once, when output enable goes away
    if (!host_chip_enable_n && !host_output_enable_n && rb_base[6]) begin
      next_s.rd_armed = 1'b1;
      next_s.rd_odd   = s.bus_width | s.addr[0];
    end else if (host_output_enable_n) begin
      next_s.rd_armed = 1'b0;
    end
    if (s.rd_armed && host_output_enable_n && s.rd_odd &&
        s.mode == hpb_pkg::HPB_READ && s.count != '0) begin
      pop = 1'b1;
    end

    // register writes, one or two byte lanes
    if (commit && !wb_base[6]) begin
      for (int k = 0; k < 2; k++) begin
        ba = wb_base | 7'(k);
        bd = (k == 0) ? s.wdata[7:0] : s.wdata[15:8];
        if (k == 0 || s.bus_width) begin
          case ({ba[6:2], 2'b00})
            hpb_pkg::A_BUSW0: begin
              if (ba[1] == 1'b0 && (k == 0 || !s.bus_width)) begin
                next_s.bus_width = bd[0];
              end
            end
            hpb_pkg::A_HLBA: begin
              case (ba[1:0])
                2'b00:   next_s.host_lba[7:0]   = bd;
                2'b01:   next_s.host_lba[15:8]  = bd;
                2'b10:   next_s.host_lba[23:16] = bd;
                default: next_s.host_lba[27:24] = bd[3:0];
              endcase
            end
            hpb_pkg::A_SCC: begin
              if (ba[1:0] == 2'b00) next_s.sec_cmd[7:0] = bd;
              if (ba[1:0] == 2'b01) begin
                next_s.sec_cmd[15:8] = bd;
                next_s.cmd_start     = 1'b1;
              end
            end
            hpb_pkg::A_CTRL: begin
              case (ba[1:0])
                2'b00:   next_s.ctrl[7:0]   = bd;
                2'b01:   next_s.ctrl[15:8]  = bd;
                2'b10:   next_s.ctrl[23:16] = bd;
                default: next_s.ctrl[31:24] = bd;
              endcase
            end
            default: ;
          endcase
        end
      end
    end

    // buffer write from the host; low byte staged in byte mode
    if (commit && wb_base[6]) begin
      if (!s.ready || s.mode != hpb_pkg::HPB_WRITE) begin
        push = 1'b0;
      end else if (s.bus_width) begin
        push = 1'b1;
      end else if (!s.waddr[0]) begin
        next_s.stage = s.wdata[7:0];
      end else begin
        push      = 1'b1;
        push_word = {s.wdata[7:0], s.stage};
      end
    end

    // card side: fills in read direction, drains in write direction
    fill  = card_fill_valid & s.fill_ready;
    drain = s.drain_valid & card_drain_ready;

    // a new command restarts the buffer and fixes its direction
    if (s.cmd_start) begin
      next_s.wptr  = '0;
      next_s.rptr  = '0;
      next_s.count = '0;
      words = (s.sec_cmd[7:0] == 8'h00) ? hpb_pkg::MAX_SECTORS :
              {9'h000, s.sec_cmd[7:0]};
      words = 17'(words * hpb_pkg::SECTOR_WORDS);
      case (s.sec_cmd[15:8])
        hpb_pkg::CMD_IDENTIFY: begin
          next_s.mode      = hpb_pkg::HPB_READ;
          next_s.dir       = 1'b0;
          next_s.host_left = hpb_pkg::SECTOR_WORDS;
          next_s.fill_left = hpb_pkg::SECTOR_WORDS;
        end
        hpb_pkg::CMD_READ: begin
          next_s.mode      = hpb_pkg::HPB_READ;
          next_s.dir       = 1'b0;
          next_s.host_left = words;
          next_s.fill_left = words;
        end
        hpb_pkg::CMD_WRITE: begin
          next_s.mode      = hpb_pkg::HPB_WRITE;
          next_s.dir       = 1'b1;
          next_s.host_left = words;
          next_s.fill_left = 17'h00000;
        end
        default: next_s.mode = hpb_pkg::HPB_IDLE;
      endcase
    end else begin
      case (s.mode)
        hpb_pkg::HPB_READ: begin
          if (fill) begin
            next_s.mem[s.wptr] = card_fill_data;
            next_s.wptr        = s.wptr + 1'b1;
            next_s.fill_left   = s.fill_left - 1'b1;
          end
          if (pop) begin
            next_s.rptr      = s.rptr + 1'b1;
            next_s.host_left = s.host_left - 1'b1;
          end
          next_s.count = s.count + hpb_pkg::CW'(fill) - hpb_pkg::CW'(pop);
          if (next_s.host_left == '0) next_s.mode = hpb_pkg::HPB_IDLE;
        end
        hpb_pkg::HPB_WRITE: begin
          if (push) begin
            next_s.mem[s.wptr] = push_word;
            next_s.wptr        = s.wptr + 1'b1;
            next_s.host_left   = s.host_left - 1'b1;
          end
          if (drain) next_s.rptr = s.rptr + 1'b1;
          next_s.count = s.count + hpb_pkg::CW'(push) - hpb_pkg::CW'(drain);
          // stays in write direction until the card took every word
          if (next_s.host_left == '0 && next_s.count == '0) begin
            next_s.mode = hpb_pkg::HPB_IDLE;
          end
        end
        default: next_s.count = s.count;
      endcase
    end

    // ready follows the next fill level so it drops two cycles on
    next_s.ready = (next_s.mode == hpb_pkg::HPB_READ) ? (next_s.count != '0) :
                   (next_s.mode == hpb_pkg::HPB_WRITE) ?
                   (next_s.count != hpb_pkg::CW'(hpb_pkg::DEPTH) && next_s.host_left != '0) :
                   1'b0;
    next_s.fill_ready  = next_s.mode == hpb_pkg::HPB_READ &&
                         next_s.count != hpb_pkg::CW'(hpb_pkg::DEPTH) && next_s.fill_left != '0;
    next_s.drain_valid = next_s.mode == hpb_pkg::HPB_WRITE && next_s.count != '0;
    next_s.drain_data  = next_s.mem[next_s.rptr];

    // read data two cycles after chip enable, lanes per bus width
    next_s.dout = s.bus_width ?
                  {rd_byte(s, rb_base | 7'h01, status_in | stat_own(s),
                           error_in, config_lba_in, fat_status_in),
                   rd_byte(s, rb_base, status_in | stat_own(s),
                           error_in, config_lba_in, fat_status_in)} :
                  {8'h00, rd_byte(s, s.addr, status_in | stat_own(s),
                                  error_in, config_lba_in, fat_status_in)};
    next_s.doe_n = host_chip_enable_n | host_output_enable_n;

    // interrupt: sticky pending, held down while the clear bit is set
    next_s.err_q = |error_in;
    brdy_rise = next_s.ready & ~s.ready;
    err_rise  = (|error_in) & ~s.err_q;
    events    = (brdy_rise & s.ctrl[hpb_pkg::CTRL_EN_BRDY]) |
                (err_rise & s.ctrl[hpb_pkg::CTRL_EN_ERR]) |
                (config_done_event & s.ctrl[hpb_pkg::CTRL_EN_CFG]);
    any_en    = |s.ctrl[hpb_pkg::CTRL_EN_CFG:hpb_pkg::CTRL_EN_BRDY];
    // the clear bit wins: no request can arm until software drops it
    next_s.pending = s.ctrl[hpb_pkg::CTRL_CLR_IRQ] ? 1'b0 : (s.pending | events);
    next_s.irq     = s.pending & any_en & ~s.ctrl[hpb_pkg::CTRL_CLR_IRQ];
  end

  // status bits owned by this block
  function automatic logic [31:0] stat_own(input hpb_pkg::hpb_state_t st);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[hpb_pkg::STAT_BRDY] = st.ready;
    v[hpb_pkg::STAT_DIR]  = st.dir;
    return v;
  endfunction : stat_own

  // whole port state in one register, frozen while clk_en is low
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s       <= '0;
      s.doe_n <= 1'b1;
      s.mode  <= hpb_pkg::HPB_IDLE;
    end else if (clk_en) begin
      s <= next_s;
    end
  end

  // outputs straight from the state register
  assign host_data_out        = s.dout;
  assign host_data_oe_n       = s.doe_n;
  assign buffer_ready_out     = s.ready;
  assign host_irq_out         = s.irq;
  assign card_fill_ready      = s.fill_ready;
  assign card_drain_valid     = s.drain_valid;
  assign card_drain_data      = s.drain_data;
  assign cmd_start            = s.cmd_start;
  assign sector_count_command = s.sec_cmd;
  assign host_block_address   = s.host_lba;

endmodule : hpb_host_port

// File: verif/hpb_host_port_monitor.sv
// hpb_host_port_monitor: timing checks on the host port pins.
// assumes writes shaped ce low, we low then high, committed at the edge after.
`timescale 1ns/100ps
module hpb_host_port_monitor (
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic [6:0]  host_address,
  input wire logic [15:0] host_data_in,
  input wire logic [15:0] host_data_out,
  input wire logic        host_chip_enable_n,
  input wire logic        host_write_enable_n,
  input wire logic        host_output_enable_n,
  input wire logic        buffer_ready_out,
  input wire logic        host_irq_out
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic        wv, bw, cm, hw, rsv, rw;
  logic [6:0]  wa;
  logic [15:0] wd;
  logic [7:0]  hi, hn;
  // commit strobe and the control high byte as the write would land in it
  assign cm  = wv && host_write_enable_n;
  // a host access cycle: chip enabled with output or write enable low
  assign rw  = !host_chip_enable_n && !(host_output_enable_n && host_write_enable_n);
  assign hw  = bw ? (wa[6:1] == 6'h0c) : (wa == 7'h19);
  assign hn  = bw ? wd[15:8] : wd[7:0];
  assign rsv = (host_address[6:1] == 6'h01) || (host_address inside {[7'h1e:7'h3f]});
  // shadow of bus width and irq control bits, so checks need no internal taps
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wv <= 1'b0;
      bw <= 1'b0;
      hi <= 8'h00;
    end else if (!host_chip_enable_n && !host_write_enable_n) begin
      wv <= 1'b1;
      wa <= host_address;
      wd <= host_data_in;
    end else if (cm) begin
      wv <= 1'b0;
      if (wa[6:1] == 6'h00) bw <= wd[0];
      if (hw) hi <= hn;
    end
  end
  property p_irq_off;
    (hi[2:0] == 3'b000) [*3] |-> !host_irq_out;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq high, enables clear");
  property p_irq_clear;
    cm && hw && hn[3] && host_irq_out |=> host_irq_out ##1 !host_irq_out;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("irq clear timing");
  property p_irq_hold;
    host_irq_out && !hi[3] && (hi[2:0] != 3'b000) |=> host_irq_out;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped early");
  property p_rdy_fall;
    $fell(buffer_ready_out) |->
      $past(rw, 2);
  endproperty
  a_rdy_fall: assert property (p_rdy_fall) else $error("ready fell off time");
  property p_byte_lane;
    (!bw) [*3] |-> host_data_out[15:8] == 8'h00;
  endproperty
  a_byte_lane: assert property (p_byte_lane) else $error("high lane in byte mode");
  property p_rsv;
    (!host_chip_enable_n && !bw && rsv && $stable(host_address)) [*3] |-> host_data_out == 16'h0000;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved read not zero");
  property p_rev_byte;
    (!host_chip_enable_n && !bw && host_address == hpb_pkg::A_REV && $stable(host_address)) [*3]
      |-> host_data_out == {8'h00, hpb_pkg::REVISION[7:0]};
  endproperty
  a_rev_byte: assert property (p_rev_byte) else $error("byte revision read");
  property p_rev_word;
    (!host_chip_enable_n && bw && host_address[6:1] == 6'h0b) [*3]
      |-> host_data_out == hpb_pkg::REVISION;
  endproperty
  a_rev_word: assert property (p_rev_word) else $error("word revision read");
  c_clear: cover property (cm && hw && hn[3]);
  c_irq: cover property ($rose(host_irq_out));
  c_rdy: cover property ($fell(buffer_ready_out));
endmodule : hpb_host_port_monitor

bind hpb_host_port hpb_host_port_monitor mon_u (
  .sys_clk(sys_clk), .rstn(rstn), .host_address(host_address),
  .host_data_in(host_data_in), .host_data_out(host_data_out),
  .host_chip_enable_n(host_chip_enable_n), .host_write_enable_n(host_write_enable_n),
  .host_output_enable_n(host_output_enable_n), .buffer_ready_out(buffer_ready_out),
  .host_irq_out(host_irq_out)
);

// File: verif/hpb_card_model.sv
// hpb_card_model: card engine stand-in on the buffer fill and drain sides.
// assumes read words 16'h1000+n and write words 16'h2000+n, in order.
`timescale 1ns/100ps
module hpb_card_model (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        stall,
  output logic             fill_valid,
  output logic      [15:0] fill_data,
  input  wire logic        fill_ready,
  input  wire logic        drain_valid,
  input  wire logic [15:0] drain_data,
  output logic             drain_ready,
  output logic      [8:0]  drained,
  output logic      [7:0]  bad
);
  logic [8:0] filled;
  // a stalled card shows inverted data so a stray capture cannot look right
  assign fill_valid  = !stall;
  assign fill_data   = stall ? ~(16'h1000 + {7'h00, filled}) : 16'h1000 + {7'h00, filled};
  assign drain_ready = !stall;
  // counts words both ways; drained words must come in write order
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      filled  <= 9'h000;
      drained <= 9'h000;
      bad     <= 8'h00;
    end else begin
      if (fill_valid && fill_ready) filled <= filled + 9'h001;
      if (drain_valid && drain_ready) begin
        drained <= drained + 9'h001;
        if (drain_data !== 16'h2000 + {7'h00, drained}) bad <= bad + 8'h01;
      end
    end
  end
endmodule : hpb_card_model

// File: verif/hpb_host_port_tb_top.sv
// hpb_host_port_tb_top: register map, interrupt and buffer tests.
// assumes the card model answers at once unless the bench stalls it.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module hpb_host_port_tb_top;
  logic        sys_clk = 1'b0;
  logic        rstn    = 1'b0;
  logic [6:0]  addr    = 7'h00;
  logic [15:0] din     = 16'h0000;
  logic        ce_n    = 1'b1;
  logic        we_n    = 1'b1;
  logic        oe_n    = 1'b1;
  logic        stall   = 1'b0;
  logic [31:0] err     = 32'h0;
  logic [31:0] lba     = 32'hff332211;
  logic [15:0] dout, rd_v, fd, dd, scc;
  logic        rdy, irq, fv, fr, dv, dr, doe_n, doe_v, cs;
  int          starts      = 0;
  logic [27:0] hba;
  logic [8:0]  drained;
  logic [7:0]  bad;
  int          fail_count  = 0;
  int          comparisons = 0;
  always #25 sys_clk = ~sys_clk;
  hpb_host_port dut_u (
    .sys_clk(sys_clk), .rstn(rstn), .clk_en(1'b1), .host_address(addr),
    .host_data_in(din), .host_data_out(dout), .host_data_oe_n(doe_n),
    .host_chip_enable_n(ce_n), .host_write_enable_n(we_n),
    .host_output_enable_n(oe_n), .buffer_ready_out(rdy), .host_irq_out(irq),
    .status_in(32'h0), .error_in(err), .config_lba_in(28'h0), .fat_status_in(16'h0),
    .config_done_event(1'b0), .card_fill_valid(fv), .card_fill_data(fd),
    .card_fill_ready(fr), .card_drain_valid(dv), .card_drain_data(dd),
    .card_drain_ready(dr), .cmd_start(cs), .sector_count_command(scc), .host_block_address(hba)
  );
  // counts command start pulses handed to the card side
  always @(posedge sys_clk) begin
    if (cs === 1'b1) starts++;
  end
  hpb_card_model card_u (
    .sys_clk(sys_clk), .rstn(rstn), .stall(stall), .fill_valid(fv), .fill_data(fd),
    .fill_ready(fr), .drain_valid(dv), .drain_data(dd), .drain_ready(dr),
    .drained(drained), .bad(bad)
  );
  // host write: ce low, we low with data, we high, then release
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge sys_clk) #2;
    ce_n = 1'b0;
    addr = a;
    @(posedge sys_clk) #2;
    we_n = 1'b0;
    din  = d;
    @(posedge sys_clk) #2;
    we_n = 1'b1;
    @(posedge sys_clk) #2;
    ce_n = 1'b1;
  endtask : wr
  // host read: data taken at the edge that ends the output enable cycle
  task automatic rd(input logic [6:0] a);
    @(posedge sys_clk) #2;
    ce_n = 1'b0;
    addr = a;
    @(posedge sys_clk) #2;
    @(posedge sys_clk) #2;
    oe_n = 1'b0;
    @(posedge sys_clk);
    rd_v = dout;
    #2;
    oe_n = 1'b1;
    doe_v = doe_n;
    @(posedge sys_clk) #2;
    ce_n = 1'b1;
  endtask : rd
  task automatic rdc(input logic [6:0] a, input logic [15:0] e);
    rd(a);
    `CHK("read data", e, rd_v)
    `CHK("data enable", 1'b0, doe_v)
  endtask : rdc
  // bounded wait so a stuck ready is reported instead of hanging
  task automatic wait_rdy;
    for (int n = 0; n < 400 && rdy !== 1'b1; n++) @(posedge sys_clk) #2;
    `CHK("buffer ready", 1'b1, rdy)
  endtask : wait_rdy
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up
  // watchdog: the tests need about 2500 cycles, this allows 40000
  initial begin
    #2000000;
    fail_count++;
    wrap_up;
  end
  // main sequence: byte map, interrupt, word mode read and write commands
  initial begin
    repeat (20) @(posedge sys_clk);
    #2;
    rstn = 1'b1;
    rdc(7'h00, 16'h0000);
    rdc(hpb_pkg::A_REV, {8'h00, hpb_pkg::REVISION[7:0]});
    rdc(7'h17, {8'h00, hpb_pkg::REVISION[15:8]});
    wr(7'h02, 16'h00ff);
    rdc(7'h02, 16'h0000);
    err = 32'h000000a5;
    wr(hpb_pkg::A_ERR, 16'h005a);
    rdc(hpb_pkg::A_ERR, 16'h00a5);
    `CHK("irq", 1'b0, irq)
    for (int i = 0; i < 4; i++) begin
      wr(hpb_pkg::A_HLBA + 7'(i), {8'h00, lba[8*i +: 8]});
    end
    `CHK("block address", 28'hf332211, hba)
    rdc(7'h13, 16'h000f);
    $display("test registers done");
    err = 32'h0;
    wr(7'h19, 16'h0002);
    err = 32'h00000001;
    for (int n = 0; n < 20 && irq !== 1'b1; n++) @(posedge sys_clk) #2;
    repeat (6) @(posedge sys_clk) #2;
    `CHK("irq", 1'b1, irq)
    wr(7'h19, 16'h000a);
    @(posedge sys_clk) #2;
    `CHK("irq", 1'b0, irq)
    wr(7'h19, 16'h0002);
    err = 32'h0;
    @(posedge sys_clk) #2;
    err = 32'h00000001;
    for (int n = 0; n < 20 && irq !== 1'b1; n++) @(posedge sys_clk) #2;
    `CHK("irq", 1'b1, irq)
    wr(7'h19, 16'h0008);
    wr(7'h19, 16'h0000);
    `CHK("irq", 1'b0, irq)
    $display("test interrupt done");
    wr(7'h00, 16'h0001);
    rdc(7'h16, hpb_pkg::REVISION);
    rdc(7'h03, 16'h0000);
    rdc(7'h01, 16'h0001);
    wr(7'h14, {hpb_pkg::CMD_READ, 8'h01});
    wait_rdy;
    rdc(hpb_pkg::A_STAT, 16'h0040);
    for (int i = 0; i < 256; i++) begin
      wait_rdy;
      rdc(7'h40 + 7'((i % 32) * 2), 16'h1000 + 16'(i));
    end
    `CHK("buffer ready", 1'b0, rdy)
    $display("test read done");
    stall = 1'b1;
    wr(7'h14, {hpb_pkg::CMD_WRITE, 8'h01});
    `CHK("sector command", {hpb_pkg::CMD_WRITE, 8'h01}, scc)
    wait_rdy;
    rdc(hpb_pkg::A_STAT, 16'h00c0);
    for (int i = 0; i < 16; i++) begin
      wr(7'h40, 16'h2000 + 16'(i));
    end
    `CHK("buffer ready", 1'b0, rdy)
    wr(7'h40, 16'hdead);
    stall = 1'b0;
    for (int i = 16; i < 256; i++) begin
      wait_rdy;
      wr(7'h40 + 7'((i % 32) * 2), 16'h2000 + 16'(i));
    end
    for (int n = 0; n < 100 && drained !== 9'h100; n++) @(posedge sys_clk) #2;
    `CHK("words drained", 9'h100, drained)
    `CHK("drain order", 8'h00, bad)
    `CHK("buffer ready", 1'b0, rdy)
    `CHK("command starts", 2, starts)
    $display("test write done");
    wrap_up;
  end
endmodule : hpb_host_port_tb_top
